// ===== rtl/vtic_map.svh
// register offsets, field positions, reset values and timing counts
// assumes a byte-addressed plain register port with 8-bit address
`ifndef VTIC_MAP_SVH
`define VTIC_MAP_SVH
`define VTIC_OFF_CTRL 8'h00
`define VTIC_OFF_STATUS 8'h04
`define VTIC_OFF_IRQ_EN 8'h08
`define VTIC_OFF_IRQ_CLR 8'h0C
`define VTIC_OFF_MAIN 8'h10
`define VTIC_OFF_START_FRAC 8'h14
`define VTIC_OFF_STOP_FRAC 8'h18
`define VTIC_OFF_RESULT 8'h1C
`define VTIC_OFF_AVG_SUM 8'h20
`define VTIC_OFF_AVG_N 8'h24
`define VTIC_OFF_CAL 8'h28
`define VTIC_OFF_LEVEL 8'h2C
// control fields
`define VTIC_CTRL_ARM 0
`define VTIC_CTRL_VERNIER 1
`define VTIC_CTRL_CAL 2
`define VTIC_CTRL_SLOPE_NEG 3
`define VTIC_CTRL_HYST 4
`define VTIC_CTRL_AVG 5
`define VTIC_CTRL_AVG_CLR 6
// status / interrupt fields
`define VTIC_ST_DONE 0
`define VTIC_ST_CAL_DONE 1
`define VTIC_ST_BUSY 2
`define VTIC_ST_CAL_BUSY 3
`define VTIC_IRQ_BITS 2
// interpolator and clock figures
`define VTIC_STRETCH 1000
`define VTIC_ANALOG_PERIOD_NS 100
`define VTIC_VERN_PERIOD_NS 5
`define VTIC_VERN_N 256
`define VTIC_VERN_RES_PS 20
// trigger level figures
`define VTIC_CAL_STEP_MV 16'sh0001
`define VTIC_LEVEL_STEP_MV 10
`define VTIC_MV_PER_V 1000
`define VTIC_DIGIT_MAX_V 4'h9
`define VTIC_DIGIT_MAX_H 7'h63
`define VTIC_CAL_SPAN_MV 16'sh0064
// calibration settle time per step
`define VTIC_CLK_NS 25
`define VTIC_CAL_SETTLE_NS 1000
`define VTIC_CAL_SETTLE_CYC ((`VTIC_CAL_SETTLE_NS + `VTIC_CLK_NS - 1) / `VTIC_CLK_NS)
`define VTIC_LFSR_SEED 16'hACE1
`endif

// ===== rtl/vtic_pkg.sv
// types shared by the interval counter files
// assumes the offset header is included where numbers are needed
package vtic_pkg;
    typedef enum logic [1:0] {VTIC_IDLE, VTIC_RUN, VTIC_DONE} vtic_meas_type;
    typedef enum logic {VTIC_CAL_IDLE, VTIC_CAL_RUN} vtic_cal_type;
    typedef logic [23:0] vtic_count_type;
endpackage

// ===== rtl/vtic_gate_counter.sv
// synchronized gate with a pulse counter behind it
// assumes open and close requests are single-cycle pulses on clk
`timescale 1ns/1ps
module vtic_gate_counter
    import vtic_pkg::*;
#(
    parameter int WIDTH = 24
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic clr,
    input wire logic open_req,
    input wire logic close_req,
    input wire logic inc,
    output logic gate_open,
    output logic [WIDTH-1:0] count
);
    // request arms, the next edge switches the gate
    always_ff @(posedge clk) begin
        if (srst || clr) begin
            gate_open <= 1'b0;
        end else if (close_req) begin
            gate_open <= 1'b0;
        end else if (open_req) begin
            gate_open <= 1'b1;
        end
    end

    // whole pulses only, while the gate stands open
    always_ff @(posedge clk) begin
        if (srst || clr) begin
            count <= '0;
        end else if (gate_open && inc) begin
            count <= count + WIDTH'(1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_gate_on_edge: assert property (open_req && !close_req && !clr |=> gate_open)
        else $error("gate did not open on next edge");
    a_count_frozen: assert property (!gate_open && !clr |=> $stable(count))
        else $error("count moved with gate closed");
    a_count_step: assert property (gate_open && inc && !clr |=> count == $past(count) + WIDTH'(1))
        else $error("count did not step by one");
endmodule // vtic_gate_counter

// ===== rtl/vtic_core.sv
// time-interval counter: analog stretch and dual vernier schemes,
// averaging, trigger level and calibration sequencer
// assumes all event pins are asynchronous to clk; register port on clk
//
// Operation
// - main count spans first clock after start to first clock after stop
// - start and stop fractions captured; result is main plus start minus stop
// - fractions stretched 1000 times, measured by counting main clocks
// - analog result: main plus fractions over 1000, at 100 ns period
// - vernier: start and stop each launch their own triggered oscillator
// - vernier counts stop at start and stop coincidence respectively
// - coincidences gate a signed main burst, negative if stop first
// - reference vernier setup: 5 ns clock, factor 256, 20 ps resolution
// - counting gates switch only on clock edges
// - averaging adds random phase jitter to the measurement clock
// - averaging accumulates readings and sample count for the mean
// - calibration steps reference 1 mV until comparator fires, then holds
// - manual level from two digit selectors, +-9.99 V in 10 mV steps
// - hysteresis compensation adds half band, subtracted on negative slope
// - events only arm the gate; next clock edge switches it
//
// The address map and strobed register access were left to the implementer.
`include "vtic_map.svh"
`timescale 1ns/1ps
module vtic_core
    import vtic_pkg::*;
#(
    parameter logic signed [15:0] HYST_HALF_MV = 16'sh0014
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic start_event,
    input wire logic stop_event,
    input wire logic start_stretch_busy,
    input wire logic stop_stretch_busy,
    input wire logic start_vernier_tick,
    input wire logic stop_vernier_tick,
    input wire logic start_coincidence,
    input wire logic stop_coincidence,
    input wire logic comparator_fire,
    input wire logic [3:0] level_volts,
    input wire logic [6:0] level_hundredths,
    input wire logic level_negative,
    output logic start_osc_run,
    output logic stop_osc_run,
    output logic [7:0] clock_jitter,
    output logic signed [15:0] ref_level_mv,
    output logic measure_done,
    output logic irq
);
    localparam int PINS = 21;
    localparam int CAL_CYC = `VTIC_CAL_SETTLE_CYC;
    // reference vernier resolution in ps, rounded, for the processor side
    localparam int VERN_RES_PS =
        (`VTIC_VERN_PERIOD_NS * 1000 + `VTIC_VERN_N / 2) / `VTIC_VERN_N;

    logic [PINS-1:0] pin_raw, sync1, sync2, sync3;
    logic st_rise, sp_rise, sb_rise, sb_fall, pb_rise, pb_fall;
    logic st_tick, sp_tick, sc_rise, pc_rise, fire_s;
    logic vernier, slope_neg, hyst_en, avg_en;
    logic arm_pulse, cal_req, avg_clr;
    vtic_meas_type state;
    vtic_cal_type cal_state;
    logic active, start_seen, stop_seen, sfrac_done, pfrac_done;
    logic start_coin_seen, stop_coin_seen, burst_neg;
    logic sc, pc, done_cond, done_pulse, cal_done_pulse;
    logic a_open, a_close, b_open, b_close, b_inc, c_open, c_close, c_inc;
    logic gate_a, gate_b, gate_c;
    vtic_count_type cnt_a, cnt_b, cnt_c;
    logic signed [23:0] main_signed;
    logic [31:0] result;
    logic [47:0] avg_sum;
    logic [23:0] avg_n;
    logic [1:0] status, irq_en;
    logic signed [15:0] cal_ref, cal_offset, level_mv, next_ref;
    logic [7:0] cal_timer;
    logic [15:0] lfsr;
    logic [3:0] volts_c;
    logic [6:0] hund_c;

    // every pin passes three flops; edges taken from the second and third
    assign pin_raw = {level_negative, level_hundredths, level_volts, comparator_fire,
                      stop_coincidence, start_coincidence, stop_vernier_tick,
                      start_vernier_tick, stop_stretch_busy, start_stretch_busy,
                      stop_event, start_event};
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end
    assign st_rise = sync2[0] & ~sync3[0];
    assign sp_rise = sync2[1] & ~sync3[1];
    assign sb_rise = sync2[2] & ~sync3[2];
    assign sb_fall = ~sync2[2] & sync3[2];
    assign pb_rise = sync2[3] & ~sync3[3];
    assign pb_fall = ~sync2[3] & sync3[3];
    assign st_tick = sync2[4] & ~sync3[4];
    assign sp_tick = sync2[5] & ~sync3[5];
    assign sc_rise = sync2[6] & ~sync3[6];
    assign pc_rise = sync2[7] & ~sync3[7];
    assign fire_s = sync2[8];

    // control register and its self-clearing pulses
    assign arm_pulse = wr && addr == `VTIC_OFF_CTRL && wdata[`VTIC_CTRL_ARM];
    assign cal_req = wr && addr == `VTIC_OFF_CTRL && wdata[`VTIC_CTRL_CAL];
    assign avg_clr = wr && addr == `VTIC_OFF_CTRL && wdata[`VTIC_CTRL_AVG_CLR];
    always_ff @(posedge clk) begin
        if (srst) begin
            vernier <= 1'b0;
            slope_neg <= 1'b0;
            hyst_en <= 1'b0;
            avg_en <= 1'b0;
            irq_en <= '0;
        end else if (wr) begin
            if (addr == `VTIC_OFF_CTRL) begin
                vernier <= wdata[`VTIC_CTRL_VERNIER];
                slope_neg <= wdata[`VTIC_CTRL_SLOPE_NEG];
                hyst_en <= wdata[`VTIC_CTRL_HYST];
                avg_en <= wdata[`VTIC_CTRL_AVG];
            end
            if (addr == `VTIC_OFF_IRQ_EN) begin
                irq_en <= wdata[`VTIC_IRQ_BITS-1:0];
            end
        end
    end

    // measurement sequence
    assign active = state == VTIC_RUN;
    assign sc = active && vernier && start_osc_run && sc_rise;
    assign pc = active && vernier && stop_osc_run && pc_rise;
    assign done_cond = !gate_a && !gate_b && !gate_c && (vernier
        ? (start_coin_seen && stop_coin_seen)
        : (start_seen && stop_seen && sfrac_done && pfrac_done));
    assign done_pulse = active && done_cond;
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= VTIC_IDLE;
        end else if (arm_pulse) begin
            state <= VTIC_RUN;
        end else begin
            case (state)
                VTIC_IDLE: state <= VTIC_IDLE;
                VTIC_RUN: if (done_cond) state <= VTIC_DONE;
                VTIC_DONE: state <= VTIC_DONE;
                default: state <= VTIC_IDLE;
            endcase
        end
    end

    // event bookkeeping, cleared when the next measurement is armed
    always_ff @(posedge clk) begin
        if (srst || arm_pulse) begin
            start_seen <= 1'b0;
            stop_seen <= 1'b0;
            sfrac_done <= 1'b0;
            pfrac_done <= 1'b0;
            start_coin_seen <= 1'b0;
            stop_coin_seen <= 1'b0;
            burst_neg <= 1'b0;
        end else if (active) begin
            if (st_rise) start_seen <= 1'b1;
            if (sp_rise && (start_seen || st_rise || vernier)) stop_seen <= 1'b1;
            if (sb_fall && start_seen) sfrac_done <= 1'b1;
            if (pb_fall && stop_seen) pfrac_done <= 1'b1;
            if (sc) start_coin_seen <= 1'b1;
            if (pc) stop_coin_seen <= 1'b1;
            if (pc && !sc && !start_coin_seen) burst_neg <= 1'b1;
        end
    end

    // triggered oscillators run from their event to their coincidence
    always_ff @(posedge clk) begin
        if (srst || arm_pulse) begin
            start_osc_run <= 1'b0;
            stop_osc_run <= 1'b0;
        end else begin
            if (sc) start_osc_run <= 1'b0;
            else if (active && vernier && st_rise && !start_seen) start_osc_run <= 1'b1;
            if (pc) stop_osc_run <= 1'b0;
            else if (active && vernier && sp_rise && !stop_seen) stop_osc_run <= 1'b1;
        end
    end

    // gate requests per scheme
    always_comb begin
        if (vernier) begin
            a_open = (sc || pc) && !start_coin_seen && !stop_coin_seen;
            a_close = (sc && (stop_coin_seen || pc)) || (pc && (start_coin_seen || sc));
            b_open = active && st_rise && !start_seen;
            b_close = sc;
            b_inc = st_tick;
            c_open = active && sp_rise && !stop_seen;
            c_close = pc;
            c_inc = sp_tick;
        end else begin
            a_open = active && st_rise && !start_seen;
            a_close = active && sp_rise && (start_seen || st_rise);
            b_open = active && sb_rise && (start_seen || st_rise);
            b_close = sb_fall;
            b_inc = 1'b1;
            c_open = active && pb_rise && (stop_seen || sp_rise);
            c_close = pb_fall;
            c_inc = 1'b1;
        end
    end

    vtic_gate_counter #(.WIDTH(24)) u_main (
        .clk(clk), .srst(srst), .clr(arm_pulse), .open_req(a_open), .close_req(a_close),
        .inc(1'b1), .gate_open(gate_a), .count(cnt_a));
    vtic_gate_counter #(.WIDTH(24)) u_start (
        .clk(clk), .srst(srst), .clr(arm_pulse), .open_req(b_open), .close_req(b_close),
        .inc(b_inc), .gate_open(gate_b), .count(cnt_b));
    vtic_gate_counter #(.WIDTH(24)) u_stop (
        .clk(clk), .srst(srst), .clr(arm_pulse), .open_req(c_open), .close_req(c_close),
        .inc(c_inc), .gate_open(gate_c), .count(cnt_c));

    // signed burst and combined reading in stretched clock units
    assign main_signed = burst_neg ? -$signed(cnt_a) : $signed(cnt_a);
    always_ff @(posedge clk) begin
        if (srst || arm_pulse) begin
            result <= '0;
            measure_done <= 1'b0;
        end else if (done_pulse) begin
            result <= 32'(main_signed * `VTIC_STRETCH) + 32'(cnt_b) - 32'(cnt_c);
            measure_done <= 1'b1;
        end
    end

    // averaging accumulator
    always_ff @(posedge clk) begin
        if (srst || avg_clr) begin
            avg_sum <= '0;
            avg_n <= '0;
        end else if (avg_en && state == VTIC_DONE && measure_done && arm_pulse) begin
            avg_sum <= avg_sum + 48'($signed(result));
            avg_n <= avg_n + 24'h00_0001;
        end
    end

    // noise source for clock phase modulation while averaging
    always_ff @(posedge clk) begin
        if (srst) begin
            lfsr <= `VTIC_LFSR_SEED;
            clock_jitter <= 8'h00;
        end else begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            clock_jitter <= avg_en ? lfsr[7:0] : 8'h00;
        end
    end

    // calibration staircase
    always_ff @(posedge clk) begin
        if (srst) begin
            cal_state <= VTIC_CAL_IDLE;
            cal_ref <= 16'sh0000;
            cal_offset <= 16'sh0000;
            cal_timer <= 8'h00;
        end else begin
            case (cal_state)
                VTIC_CAL_IDLE: if (cal_req) begin
                    cal_state <= VTIC_CAL_RUN;
                    // slope comes with the request, the stored bit lags one edge
                    cal_ref <= wdata[`VTIC_CTRL_SLOPE_NEG] ? -`VTIC_CAL_SPAN_MV
                                                          : `VTIC_CAL_SPAN_MV;
                    cal_timer <= 8'(CAL_CYC - 1);
                end
                VTIC_CAL_RUN: if (cal_timer != 8'h00) begin
                    cal_timer <= cal_timer - 8'h01;
                end else if (fire_s || cal_ref == (slope_neg ? `VTIC_CAL_SPAN_MV
                                                             : -`VTIC_CAL_SPAN_MV)) begin
                    cal_offset <= cal_ref;
                    cal_state <= VTIC_CAL_IDLE;
                end else begin
                    cal_ref <= slope_neg ? cal_ref + `VTIC_CAL_STEP_MV
                                         : cal_ref - `VTIC_CAL_STEP_MV;
                    cal_timer <= 8'(CAL_CYC - 1);
                end
                default: cal_state <= VTIC_CAL_IDLE;
            endcase
        end
    end
    assign cal_done_pulse = cal_state == VTIC_CAL_RUN && cal_timer == 8'h00 &&
        (fire_s || cal_ref == (slope_neg ? `VTIC_CAL_SPAN_MV : -`VTIC_CAL_SPAN_MV));

    // manual level from the digit selectors, then compensation
    assign volts_c = (sync2[12:9] > `VTIC_DIGIT_MAX_V) ? `VTIC_DIGIT_MAX_V : sync2[12:9];
    assign hund_c = (sync2[19:13] > `VTIC_DIGIT_MAX_H) ? `VTIC_DIGIT_MAX_H : sync2[19:13];
    always_comb begin
        level_mv = 16'(volts_c * `VTIC_MV_PER_V + hund_c * `VTIC_LEVEL_STEP_MV);
        if (sync2[20]) level_mv = -level_mv;
        next_ref = level_mv + cal_offset;
        if (hyst_en) next_ref = slope_neg ? next_ref - HYST_HALF_MV
                                          : next_ref + HYST_HALF_MV;
        if (cal_state == VTIC_CAL_RUN) next_ref = cal_ref;
    end
    always_ff @(posedge clk) begin
        if (srst) ref_level_mv <= 16'sh0000;
        else ref_level_mv <= next_ref;
    end

    // sticky status, set wins over clear; level interrupt
    always_ff @(posedge clk) begin
        if (srst) begin
            status <= '0;
            irq <= 1'b0;
        end else begin
            status <= (status & ~((wr && addr == `VTIC_OFF_IRQ_CLR) ? wdata[1:0] : 2'h0))
                      | {cal_done_pulse, done_pulse};
            irq <= |(status & irq_en);
        end
    end

    // read port, data in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst || !rd) begin
            rdata <= 32'h0000_0000;
        end else begin
            case (addr)
                `VTIC_OFF_CTRL: rdata <= 32'({avg_en, hyst_en, slope_neg, 1'b0, vernier, 1'b0});
                `VTIC_OFF_STATUS: rdata <= 32'({cal_state == VTIC_CAL_RUN, active, status});
                `VTIC_OFF_IRQ_EN: rdata <= 32'(irq_en);
                `VTIC_OFF_MAIN: rdata <= 32'(main_signed);
                `VTIC_OFF_START_FRAC: rdata <= 32'(cnt_b);
                `VTIC_OFF_STOP_FRAC: rdata <= 32'(cnt_c);
                `VTIC_OFF_RESULT: rdata <= result;
                `VTIC_OFF_AVG_SUM: rdata <= avg_sum[31:0];
                `VTIC_OFF_AVG_N: rdata <= 32'(avg_n);
                `VTIC_OFF_CAL: rdata <= 32'(cal_offset);
                `VTIC_OFF_LEVEL: rdata <= 32'(ref_level_mv);
                default: rdata <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_done_arm_clear: assert property (arm_pulse |=> !measure_done)
        else $error("done flag survived arming");
    a_done_frozen: assert property (measure_done && !arm_pulse |=> $stable(cnt_a) && $stable(cnt_b))
        else $error("counts moved after done");
    a_osc_launch: assert property (active && vernier && st_rise && !start_seen && !sc |=> start_osc_run)
        else $error("start oscillator not launched");
    a_osc_coin_stop: assert property (sc |=> !start_osc_run ##1 $stable(cnt_b))
        else $error("start vernier count not stopped");
    a_burst_sign: assert property (pc && !sc && !start_coin_seen && !arm_pulse |=> burst_neg)
        else $error("burst sign not negative");
    a_result_form: assert property (done_pulse |=> result ==
        32'($past(main_signed) * `VTIC_STRETCH) + 32'($past(cnt_b)) - 32'($past(cnt_c)))
        else $error("result formula wrong");
    a_cal_step: assert property (cal_state == VTIC_CAL_RUN && cal_timer == 8'h00 && !fire_s
        && !cal_done_pulse && !slope_neg |=> cal_ref == $past(cal_ref) - 16'sh0001)
        else $error("calibration step not 1 mV down");
    a_cal_hold: assert property (cal_done_pulse |=> cal_offset == $past(cal_ref)
        ##1 $stable(cal_offset))
        else $error("calibration value not held");
    a_hyst_offset: assert property (hyst_en && !slope_neg && cal_state == VTIC_CAL_IDLE
        && $stable(level_mv) |=> ref_level_mv == $past(level_mv) + cal_offset + HYST_HALF_MV)
        else $error("hysteresis offset wrong");
    a_irq_level: assert property (##1 irq == $past(|(status & irq_en)))
        else $error("interrupt level wrong");
    a_jitter_off: assert property (!avg_en |=> clock_jitter == 8'h00)
        else $error("jitter present outside averaging");

    c_analog_done: cover property (!vernier && done_pulse);
    c_vernier_done: cover property (vernier && done_pulse && !burst_neg);
    c_vernier_neg: cover property (vernier && done_pulse && burst_neg);
    c_cal_done: cover property (cal_done_pulse);
endmodule // vtic_core

// ===== tb/vtic_partner.sv
// far-side model: analog interpolators and trigger comparator
// assumes event pins driven by the bench on clk rising edges
`timescale 1ns/1ps
module vtic_partner #(
    parameter int SA = 30,
    parameter int SB = 12,
    parameter logic signed [15:0] TRIP = 16'sh005F
) (
    input wire logic clk,
    input wire logic start_event,
    input wire logic stop_event,
    input wire logic slope_neg,
    input wire logic signed [15:0] ref_level_mv,
    output logic start_stretch_busy,
    output logic stop_stretch_busy,
    output logic comparator_fire
);
    logic sp = 1'b0;
    logic tp = 1'b0;
    int ca = 0;
    int cb = 0;
    // stretched fraction: busy for a fixed count, 3 cycles after the event
    always_ff @(posedge clk) begin
        sp <= start_event;
        tp <= stop_event;
        ca <= (start_event && !sp) ? SA + 3 : (ca > 0 ? ca - 1 : 0);
        cb <= (stop_event && !tp) ? SB + 3 : (cb > 0 ? cb - 1 : 0);
    end
    assign start_stretch_busy = ca > 0 && ca <= SA;
    assign stop_stretch_busy = cb > 0 && cb <= SB;
    // comparator trips at a fixed level, side chosen by slope
    assign comparator_fire = slope_neg ? ref_level_mv >= -TRIP : ref_level_mv <= TRIP;
endmodule // vtic_partner

// ===== tb/vtic_core_tb.sv
// self-checking bench for the interval counter core
// assumes the partner model answers the interpolator and comparator pins
`timescale 1ns/1ps
module vtic_core_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0, rd = 1'b0, start_event = 1'b0, stop_event = 1'b0, slope_neg = 1'b0;
    logic start_vernier_tick = 1'b0, stop_vernier_tick = 1'b0;
    logic start_coincidence = 1'b0, stop_coincidence = 1'b0, level_negative = 1'b0;
    logic [3:0] level_volts = 4'h1;
    logic [6:0] level_hundredths = 7'h17;
    logic [31:0] rdata;
    logic start_stretch_busy, stop_stretch_busy, comparator_fire;
    logic start_osc_run, stop_osc_run, measure_done, irq;
    logic [7:0] clock_jitter;
    logic signed [15:0] ref_level_mv;
    int fails = 0, checked = 0, cyc = 0;
    // clock
    always #12.5 clk = ~clk;
    vtic_core u_vtic_core (.clk, .srst, .addr, .wdata, .wr, .rd, .rdata, .start_event,
        .stop_event, .start_stretch_busy, .stop_stretch_busy, .start_vernier_tick,
        .stop_vernier_tick, .start_coincidence, .stop_coincidence, .comparator_fire,
        .level_volts, .level_hundredths, .level_negative, .start_osc_run, .stop_osc_run,
        .clock_jitter, .ref_level_mv, .measure_done, .irq);
    vtic_partner u_vtic_partner (.clk, .start_event, .stop_event, .slope_neg, .ref_level_mv,
        .start_stretch_busy, .stop_stretch_busy, .comparator_fire);
    task automatic finish_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            fails++;
            finish_test();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("[ERR] %s exp %h got %h", n, e, g);
            fails++;
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) begin
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
        end
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rg(input logic [7:0] a);
        @(posedge clk) begin
            addr <= a;
            rd <= 1'b1;
        end
        @(posedge clk) rd <= 1'b0;
        #1;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rg(a);
        chk($sformatf("reg %h", a), e, rdata);
    endtask
    task automatic wait_st(input int b);
        for (int i = 0; i < 300; i++) begin
            rg(8'h04);
            if (rdata[b] === 1'b1) break;
        end
        chk($sformatf("status bit %0d", b), 32'h0000_0001, {31'h0, rdata[b]});
    endtask
    task automatic tk(input bit s, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk) begin
                start_vernier_tick <= !s;
                stop_vernier_tick <= s;
            end
            repeat (2) @(posedge clk);
            start_vernier_tick <= 1'b0;
            stop_vernier_tick <= 1'b0;
            @(posedge clk);
        end
    endtask
    // analog run: 50 cycle interval, fractions 30 and 12
    task automatic meas(input logic [31:0] c);
        w(8'h0C, 32'h0000_0001);
        w(8'h00, c | 32'h0000_0001);
        repeat (2) @(posedge clk);
        #1 chk("measure_done", 32'h0000_0000, {31'h0, measure_done});
        @(posedge clk) start_event <= 1'b1;
        repeat (50) @(posedge clk);
        stop_event <= 1'b1;
        start_event <= 1'b0;
        @(posedge clk) stop_event <= 1'b0;
        wait_st(0);
        rc(8'h10, 32'h0000_0032);
        rc(8'h14, 32'h0000_001E);
        rc(8'h18, 32'h0000_000C);
        rc(8'h1C, 32'h0000_C362);
    endtask
    // calibration both slopes, then level with hysteresis
    task automatic t_cal();
        w(8'h00, 32'h0000_0004);
        wait_st(1);
        rc(8'h28, 32'h0000_005F);
        rc(8'h2C, 32'h0000_052D);
        w(8'h00, 32'h0000_0010);
        repeat (4) @(posedge clk);
        rc(8'h2C, 32'h0000_0541);
        slope_neg <= 1'b1;
        w(8'h0C, 32'h0000_0002);
        w(8'h00, 32'h0000_000C);
        wait_st(1);
        rc(8'h28, 32'hFFFF_FFA1);
        level_volts <= 4'hF;
        level_hundredths <= 7'h78;
        level_negative <= 1'b1;
        w(8'h00, 32'h0000_0018);
        repeat (4) @(posedge clk);
        rc(8'h2C, 32'hFFFF_D887);
        chk("ref_level_mv", 32'h0000_D887, {16'h0000, ref_level_mv});
    endtask
    // vernier run with stop coincidence first
    task automatic t_vern();
        w(8'h00, 32'h0000_0003);
        @(posedge clk) start_event <= 1'b1;
        repeat (6) @(posedge clk);
        tk(1'b0, 3);
        #1 chk("start_osc_run", 32'h0000_0001, {31'h0, start_osc_run});
        @(posedge clk) stop_event <= 1'b1;
        start_event <= 1'b0;
        repeat (6) @(posedge clk);
        tk(1'b1, 2);
        stop_coincidence <= 1'b1;
        repeat (5) @(posedge clk);
        start_coincidence <= 1'b1;
        stop_event <= 1'b0;
        repeat (3) @(posedge clk);
        start_coincidence <= 1'b0;
        stop_coincidence <= 1'b0;
        wait_st(0);
        chk("start_osc_run", 32'h0000_0000, {31'h0, start_osc_run});
        chk("measure_done", 32'h0000_0001, {31'h0, measure_done});
        chk("irq", 32'h0000_0000, {31'h0, irq});
        rc(8'h10, 32'hFFFF_FFFB);
        rc(8'h14, 32'h0000_0003);
        rc(8'h18, 32'h0000_0002);
        rc(8'h00, 32'h0000_0002);
    endtask
    // reset values, read-only and unmapped places, then scenarios
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        for (int a = 0; a <= 48; a += 4) if (a != 44) rc(8'(a), 32'h0000_0000);
        w(8'h1C, 32'h1234_5678);
        w(8'h30, 32'h1234_5678);
        rc(8'h1C, 32'h0000_0000);
        rc(8'h30, 32'h0000_0000);
        t_cal();
        t_vern();
        w(8'h0C, 32'h0000_0003);
        w(8'h08, 32'h0000_0001);
        meas(32'h0000_0000);
        repeat (2) @(posedge clk);
        #1 chk("irq", 32'h0000_0001, {31'h0, irq});
        w(8'h0C, 32'h0000_0001);
        repeat (3) @(posedge clk);
        #1 chk("irq", 32'h0000_0000, {31'h0, irq});
        w(8'h00, 32'h0000_0060);
        meas(32'h0000_0020);
        chk("clock_jitter_on", 32'h0000_0001, {31'h0, clock_jitter !== 8'h00});
        meas(32'h0000_0020);
        rc(8'h24, 32'h0000_0002);
        rc(8'h20, 32'h0001_86C4);
        w(8'h00, 32'h0000_0000);
        repeat (3) @(posedge clk);
        #1 chk("clock_jitter", 32'h0000_0000, {24'h0, clock_jitter});
        finish_test();
    end
endmodule // vtic_core_tb
